// [hw/cmpc_pkg.sv]
// Purpose: Shared constants and types for the comparator control block
// Assumes: 8-bit register port, one system clock
// Notes: Register offsets are byte addresses on the register port
//
// What this block does
// - Falling edge of comparator result sets the falling flag.
// - Rising edge of comparator result sets the rising flag.
// - Edge flags stay set until software writes them clear.
// - Rising and falling edges can each raise the interrupt.
// - Current result is readable any time via read-only bit.
// - Enable bit one switches comparator on, zero switches off.
// - Disabled comparator drives its pin outputs low.
// - Raw output is asynchronous and needs no clock.
// - Latched output is clock synchronous, selectable beside raw output.
// - First comparator has two-bit positive and negative input selects.
// - Second comparator has its own two-bit input selects.
// - Control bits 3-0 hold positive and negative hysteresis fields.
// - Per-comparator response mode field selects response time.
// - Only first comparator may act as a reset source.
package cmpc_pkg;
   localparam int unsigned CMPC_ADDR_W = 8;
   localparam int unsigned CMPC_DATA_W = 8;
   localparam logic [7:0] CMPC_CTRL0_OFF = 8'h9B;
   localparam logic [7:0] CMPC_MODE0_OFF = 8'h9D;
   localparam logic [7:0] CMPC_MUX0_OFF = 8'h9F;
   localparam logic [7:0] CMPC_CTRL1_OFF = 8'h9A;
   localparam logic [7:0] CMPC_MODE1_OFF = 8'h9C;
   localparam logic [7:0] CMPC_MUX1_OFF = 8'h9E;
   localparam logic [7:0] CMPC_IRQ_STAT_OFF = 8'hA0;
   localparam logic [7:0] CMPC_IRQ_MASK_OFF = 8'hA1;
   localparam logic [7:0] CMPC_RST_SRC_OFF = 8'hA2;
   localparam logic [7:0] CMPC_PIN_SEL_OFF = 8'hA3;
   localparam int unsigned CMPC_ON_BIT = 7;
   localparam int unsigned CMPC_RESULT_BIT = 6;
   localparam int unsigned CMPC_RISE_BIT = 5;
   localparam int unsigned CMPC_FALL_BIT = 4;
   localparam int unsigned CMPC_POS_HYST_LSB = 2;
   localparam int unsigned CMPC_NEG_HYST_LSB = 0;
   localparam int unsigned CMPC_MUX_POS_LSB = 0;
   localparam int unsigned CMPC_MUX_NEG_LSB = 4;
   localparam logic [7:0] CMPC_CTRL_RESET = 8'h00;
   localparam logic [1:0] CMPC_MODE_RESET = 2'h2;
   localparam logic [7:0] CMPC_MUX_RESET = 8'h00;
   localparam int unsigned CMPC_SYNC_STAGES = 2;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cmpc_bus_t;

   typedef struct packed {
      logic on;
      logic [1:0] pos_hyst;
      logic [1:0] neg_hyst;
      logic [1:0] response;
      logic [1:0] pos_sel;
      logic [1:0] neg_sel;
   } cmpc_analog_t;
endpackage : cmpc_pkg

// [hw/cmpc_sync.sv]
// Purpose: Two-flop synchroniser for one level
// Assumes: Input is asynchronous to clk
// Notes: First stage feeds only the second stage
module cmpc_sync
   import cmpc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Level
   input wire logic async_in,
   output logic sync_out
);
   logic meta;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule : cmpc_sync

// [hw/cmpc_top.sv]
// Purpose: Control, flags and output steering for two comparators
// Assumes: Analogue results arrive asynchronously on cmp_analog_res
// Notes: Raw and routed pin outputs are combinational gates, everything else clocked
//
// The address-and-strobe port was left to the implementer.
module cmpc_top
   import cmpc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire cmpc_pkg::cmpc_bus_t bus,
   output logic [7:0] rdata,
   // Analogue core
   input wire logic [1:0] cmp_analog_res,
   output cmpc_pkg::cmpc_analog_t cmp0_analog,
   output cmpc_pkg::cmpc_analog_t cmp1_analog,
   // Pin outputs
   output logic cmp0_latched_out,
   output logic cmp1_latched_out,
   output logic cmp0_raw_out,
   output logic cmp1_raw_out,
   output logic cmp0_pin_out,
   output logic cmp1_pin_out,
   // System
   output logic irq,
   output logic cmp0_reset_req
);
   import cmpc_pkg::*;

   logic [1:0] on;
   logic [1:0][1:0] pos_hyst;
   logic [1:0][1:0] neg_hyst;
   logic [1:0][1:0] response;
   logic [1:0][1:0] pos_sel;
   logic [1:0][1:0] neg_sel;
   logic [1:0] result;
   logic [1:0] result_d;
   logic [1:0] rise_flag;
   logic [1:0] fall_flag;
   logic [3:0] irq_mask;
   logic rst_src_en;
   logic [1:0] pin_sel_raw;
   logic [1:0] rise_ev;
   logic [1:0] fall_ev;
   logic [1:0] result_valid;
   logic [3:0] stat;
   logic [7:0] next_rdata;

   // Synchroniser below is built for exactly two stages
   if (CMPC_SYNC_STAGES != 2)
   begin : g_bad_depth
      $error("synchroniser depth must be two");
   end

   // Raw path has no clock so it works in stop mode
   assign cmp0_raw_out = cmp_analog_res[0] & on[0];
   assign cmp1_raw_out = cmp_analog_res[1] & on[1];

   // Pin route picks raw or latched; the raw choice stays clock free
   assign cmp0_pin_out = on[0]
      & (pin_sel_raw[0] ? cmp_analog_res[0] : cmp0_latched_out);
   assign cmp1_pin_out = on[1]
      & (pin_sel_raw[1] ? cmp_analog_res[1] : cmp1_latched_out);

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_cmp
         logic [7:0] ctrl_off;
         logic [7:0] mode_off;
         logic [7:0] mux_off;
         logic ctrl_wr;
         assign ctrl_off = (g == 0) ? CMPC_CTRL0_OFF : CMPC_CTRL1_OFF;
         assign mode_off = (g == 0) ? CMPC_MODE0_OFF : CMPC_MODE1_OFF;
         assign mux_off = (g == 0) ? CMPC_MUX0_OFF : CMPC_MUX1_OFF;
         assign ctrl_wr = bus.wr && (bus.addr == ctrl_off);

         cmpc_sync u_sync
         (
            .clk(clk),
            .reset(reset),
            .async_in(cmp_analog_res[g]),
            .sync_out(result[g])
         );

         assign rise_ev[g] = on[g] & result_valid[g] & result[g] & ~result_d[g];
         assign fall_ev[g] = on[g] & result_valid[g] & ~result[g] & result_d[g];

         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               result_d[g] <= 1'b0;
               result_valid[g] <= 1'b0;
            end
            else
            begin
               result_d[g] <= result[g];
               result_valid[g] <= on[g];
            end
         end

         // Control fields
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               on[g] <= CMPC_CTRL_RESET[CMPC_ON_BIT];
               pos_hyst[g] <= CMPC_CTRL_RESET[CMPC_POS_HYST_LSB +: 2];
               neg_hyst[g] <= CMPC_CTRL_RESET[CMPC_NEG_HYST_LSB +: 2];
            end
            else if (ctrl_wr)
            begin
               on[g] <= bus.wdata[CMPC_ON_BIT];
               pos_hyst[g] <= bus.wdata[CMPC_POS_HYST_LSB +: 2];
               neg_hyst[g] <= bus.wdata[CMPC_NEG_HYST_LSB +: 2];
            end
         end

         // Response and input select
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               response[g] <= CMPC_MODE_RESET;
               pos_sel[g] <= CMPC_MUX_RESET[CMPC_MUX_POS_LSB +: 2];
               neg_sel[g] <= CMPC_MUX_RESET[CMPC_MUX_NEG_LSB +: 2];
            end
            else
            begin
               if (bus.wr && bus.addr == mode_off)
               begin
                  response[g] <= bus.wdata[1:0];
               end
               if (bus.wr && bus.addr == mux_off)
               begin
                  pos_sel[g] <= bus.wdata[CMPC_MUX_POS_LSB +: 2];
                  neg_sel[g] <= bus.wdata[CMPC_MUX_NEG_LSB +: 2];
               end
            end
         end

         // Sticky flags, an edge beats a same-cycle clear
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               rise_flag[g] <= 1'b0;
               fall_flag[g] <= 1'b0;
            end
            else
            begin
               if (rise_ev[g])
               begin
                  rise_flag[g] <= 1'b1;
               end
               else if (ctrl_wr && !bus.wdata[CMPC_RISE_BIT])
               begin
                  rise_flag[g] <= 1'b0;
               end
               else if (bus.wr && bus.addr == CMPC_IRQ_STAT_OFF && bus.wdata[2*g])
               begin
                  rise_flag[g] <= 1'b0;
               end
               if (fall_ev[g])
               begin
                  fall_flag[g] <= 1'b1;
               end
               else if (ctrl_wr && !bus.wdata[CMPC_FALL_BIT])
               begin
                  fall_flag[g] <= 1'b0;
               end
               else if (bus.wr && bus.addr == CMPC_IRQ_STAT_OFF && bus.wdata[2*g+1])
               begin
                  fall_flag[g] <= 1'b0;
               end
            end
         end

         assign stat[2*g] = rise_flag[g];
         assign stat[2*g+1] = fall_flag[g];
      end
   endgenerate

   // Mask, reset source and pin select registers
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         irq_mask <= 4'h0;
         rst_src_en <= 1'b0;
         pin_sel_raw <= 2'h0;
      end
      else
      begin
         if (bus.wr && bus.addr == CMPC_IRQ_MASK_OFF)
         begin
            irq_mask <= bus.wdata[3:0];
         end
         if (bus.wr && bus.addr == CMPC_RST_SRC_OFF)
         begin
            rst_src_en <= bus.wdata[0];
         end
         if (bus.wr && bus.addr == CMPC_PIN_SEL_OFF)
         begin
            pin_sel_raw <= bus.wdata[1:0];
         end
      end
   end

   // Registered outputs
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         irq <= 1'b0;
         cmp0_latched_out <= 1'b0;
         cmp1_latched_out <= 1'b0;
         cmp0_reset_req <= 1'b0;
         cmp0_analog <= '0;
         cmp1_analog <= '0;
      end
      else
      begin
         irq <= |(stat & irq_mask);
         cmp0_latched_out <= result[0] & on[0];
         cmp1_latched_out <= result[1] & on[1];
         // Reset fires when the negative input wins
         cmp0_reset_req <= rst_src_en & on[0] & result_valid[0] & ~result[0];
         cmp0_analog <= {on[0], pos_hyst[0], neg_hyst[0], response[0], pos_sel[0], neg_sel[0]};
         cmp1_analog <= {on[1], pos_hyst[1], neg_hyst[1], response[1], pos_sel[1], neg_sel[1]};
      end
   end

   // Read mux
   always_comb
   begin
      next_rdata = 8'h00;
      if (bus.addr == CMPC_CTRL0_OFF)
      begin
         next_rdata = {on[0], result[0], rise_flag[0], fall_flag[0], pos_hyst[0], neg_hyst[0]};
      end
      else if (bus.addr == CMPC_CTRL1_OFF)
      begin
         next_rdata = {on[1], result[1], rise_flag[1], fall_flag[1], pos_hyst[1], neg_hyst[1]};
      end
      else if (bus.addr == CMPC_MODE0_OFF)
      begin
         next_rdata = {6'h00, response[0]};
      end
      else if (bus.addr == CMPC_MODE1_OFF)
      begin
         next_rdata = {6'h00, response[1]};
      end
      else if (bus.addr == CMPC_MUX0_OFF)
      begin
         next_rdata = {2'h0, neg_sel[0], 2'h0, pos_sel[0]};
      end
      else if (bus.addr == CMPC_MUX1_OFF)
      begin
         next_rdata = {2'h0, neg_sel[1], 2'h0, pos_sel[1]};
      end
      else if (bus.addr == CMPC_IRQ_STAT_OFF)
      begin
         next_rdata = {4'h0, stat};
      end
      else if (bus.addr == CMPC_IRQ_MASK_OFF)
      begin
         next_rdata = {4'h0, irq_mask};
      end
      else if (bus.addr == CMPC_RST_SRC_OFF)
      begin
         next_rdata = {7'h00, rst_src_en};
      end
      else if (bus.addr == CMPC_PIN_SEL_OFF)
      begin
         next_rdata = {6'h00, pin_sel_raw};
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rdata <= 8'h00;
      end
      else if (bus.rd)
      begin
         rdata <= next_rdata;
      end
      else
      begin
         rdata <= 8'h00;
      end
   end

   // Checks
   rise_sets_a: assert property (@(posedge clk) disable iff (reset)
      rise_ev[0] |=> rise_flag[0]) else $error("rise edge did not set flag");
   fall_sets_a: assert property (@(posedge clk) disable iff (reset)
      fall_ev[1] |=> fall_flag[1]) else $error("fall edge did not set flag");
   flag_sticky_a: assert property (@(posedge clk) disable iff (reset)
      (rise_flag[0] && !bus.wr) |=> rise_flag[0]) else $error("rise flag dropped");
   irq_level_a: assert property (@(posedge clk) disable iff (reset)
      (|(stat & irq_mask)) |=> irq) else $error("irq missing");
   off_low_a: assert property (@(posedge clk) disable iff (reset)
      !on[0] |=> !cmp0_latched_out) else $error("disabled output not low");
   raw_gate_a: assert property (@(posedge clk) disable iff (reset)
      !on[1] |-> !cmp1_raw_out) else $error("raw output not gated");
   sync_delay_a: assert property (@(posedge clk) disable iff (reset)
      on[0] && $past(on[0], 3) |-> result[0] == $past(cmp_analog_res[0], 2))
      else $error("sync depth wrong");
   enable_write_a: assert property (@(posedge clk) disable iff (reset)
      (bus.wr && bus.addr == CMPC_CTRL0_OFF) |=> on[0] == $past(bus.wdata[7]))
      else $error("enable write lost");
   read_result_a: assert property (@(posedge clk) disable iff (reset)
      (bus.rd && bus.addr == CMPC_CTRL0_OFF) |=> rdata[6] == $past(result[0]))
      else $error("result readback wrong");
   reset_only0_a: assert property (@(posedge clk) disable iff (reset)
      cmp0_reset_req |-> $past(rst_src_en)) else $error("reset without enable");
   fall0_sets_a: assert property (@(posedge clk) disable iff (reset)
      fall_ev[0] |=> fall_flag[0]) else $error("falling edge did not set flag");
   rise1_sets_a: assert property (@(posedge clk) disable iff (reset)
      rise_ev[1] |=> rise_flag[1]) else $error("rising edge did not set flag");
   stat_clear_a: assert property (@(posedge clk) disable iff (reset)
      (bus.wr && bus.addr == CMPC_IRQ_STAT_OFF && bus.wdata[0] && !rise_ev[0])
      |=> !rise_flag[0]) else $error("rise flag not cleared");
   irq_clear_a: assert property (@(posedge clk) disable iff (reset)
      !(|(stat & irq_mask)) |=> !irq) else $error("irq stuck high");
   pin_off_a: assert property (@(posedge clk) disable iff (reset)
      !on[1] |-> !cmp1_pin_out) else $error("disabled pin output not low");
   latch_follow_a: assert property (@(posedge clk) disable iff (reset)
      on[1] |=> cmp1_latched_out == $past(result[1])) else $error("latched output lags");
   reset_fires_a: assert property (@(posedge clk) disable iff (reset)
      (rst_src_en && on[0] && result_valid[0] && !result[0]) |=> cmp0_reset_req)
      else $error("reset request missing");
   mode_write_a: assert property (@(posedge clk) disable iff (reset)
      (bus.wr && bus.addr == CMPC_MODE1_OFF) |=> response[1] == $past(bus.wdata[1:0]))
      else $error("response write lost");
   mux_write_a: assert property (@(posedge clk) disable iff (reset)
      (bus.wr && bus.addr == CMPC_MUX0_OFF) |=> pos_sel[0] == $past(bus.wdata[1:0]))
      else $error("input select write lost");
   rise_c: cover property (@(posedge clk) disable iff (reset) rise_ev[0]);
   fall_c: cover property (@(posedge clk) disable iff (reset) fall_ev[1]);
   irq_c: cover property (@(posedge clk) disable iff (reset) irq);
   rst_c: cover property (@(posedge clk) disable iff (reset) cmp0_reset_req);
   pin_raw_c: cover property (@(posedge clk) disable iff (reset) pin_sel_raw[1] && cmp1_pin_out);
endmodule : cmpc_top

// [sim/cmpc_top_bench.sv]
// Purpose: Self-checking bench for the comparator control block
// Assumes: Analogue results are driven directly by the bench
// Notes: Pin outputs, flags, interrupt and reset request are judged at the ports
module cmpc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import cmpc_pkg::*;

   logic clk;
   logic reset;
   cmpc_bus_t bus;
   logic [7:0] rdata;
   logic [1:0] res;
   cmpc_analog_t a0;
   cmpc_analog_t a1;
   logic lat0, lat1, raw0, raw1, pin0, pin1, irq, rst_req;
   int mismatches = 0;
   int tests_run = 0;

   cmpc_top uut (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .cmp_analog_res(res),
      .cmp0_analog(a0), .cmp1_analog(a1), .cmp0_latched_out(lat0), .cmp1_latched_out(lat1),
      .cmp0_raw_out(raw0), .cmp1_raw_out(raw1), .cmp0_pin_out(pin0), .cmp1_pin_out(pin1),
      .irq(irq), .cmp0_reset_req(rst_req));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : rd_check

   task automatic set_res(input logic [1:0] v);
      @(posedge clk);
      res <= v;
      settle(6);
   endtask : set_res

   task automatic t_reset_values;
      rd_check(CMPC_CTRL0_OFF, 8'h00);
      rd_check(CMPC_MODE0_OFF, 8'h02);
      rd_check(CMPC_MUX0_OFF, 8'h00);
      rd_check(8'h10, 8'h00);
      check(pin0, 1'b0);
   endtask : t_reset_values

   task automatic t_enable;
      set_res(2'h1);
      wr(CMPC_CTRL0_OFF, 8'h80);
      settle(4);
      check(a0.on, 1'b1);
      check(raw0, 1'b1);
      check(lat0, 1'b1);
      rd_check(CMPC_CTRL0_OFF, 8'hC0);
   endtask : t_enable

   task automatic t_edges;
      wr(CMPC_IRQ_MASK_OFF, 8'h0F);
      set_res(2'h0);
      check(irq, 1'b1);
      rd_check(CMPC_CTRL0_OFF, 8'h90);
      set_res(2'h1);
      rd_check(CMPC_CTRL0_OFF, 8'hF0);
      set_res(2'h0);
      set_res(2'h1);
      rd_check(CMPC_CTRL0_OFF, 8'hF0);
      rd_check(CMPC_IRQ_STAT_OFF, 8'h03);
      wr(CMPC_IRQ_STAT_OFF, 8'h03);
      settle(2);
      check(irq, 1'b0);
      rd_check(CMPC_CTRL0_OFF, 8'hC0);
      wr(CMPC_IRQ_MASK_OFF, 8'h00);
      set_res(2'h0);
      check(irq, 1'b0);
      rd_check(CMPC_IRQ_STAT_OFF, 8'h02);
      wr(CMPC_IRQ_MASK_OFF, 8'h02);
      settle(2);
      check(irq, 1'b1);
      wr(CMPC_IRQ_STAT_OFF, 8'h02);
      wr(CMPC_CTRL1_OFF, 8'h80);
      set_res(2'h2);
      check(raw1, 1'b1);
      check(lat1, 1'b1);
      check(pin1, 1'b1);
      rd_check(CMPC_IRQ_STAT_OFF, 8'h04);
      rd_check(CMPC_CTRL1_OFF, 8'hE0);
      wr(CMPC_IRQ_STAT_OFF, 8'h0F);
   endtask : t_edges

   task automatic t_pins;
      wr(CMPC_PIN_SEL_OFF, 8'h01);
      @(posedge clk);
      res <= 2'h3;
      @(posedge clk);
      #1;
      check(pin0, 1'b1);
      check(lat0, 1'b0);
      settle(3);
      check(lat0, 1'b1);
      wr(CMPC_PIN_SEL_OFF, 8'h00);
      settle(2);
      @(posedge clk);
      res <= 2'h2;
      @(posedge clk);
      #1;
      check(pin0, 1'b1);
      settle(3);
      check(pin0, 1'b0);
      set_res(2'h3);
      wr(CMPC_CTRL0_OFF, 8'h00);
      settle(2);
      check(raw0, 1'b0);
      check(lat0, 1'b0);
      check(pin0, 1'b0);
      wr(CMPC_IRQ_STAT_OFF, 8'h0F);
   endtask : t_pins

   task automatic t_fields;
      wr(CMPC_CTRL0_OFF, 8'h8B);
      wr(CMPC_MUX0_OFF, 8'h31);
      wr(CMPC_MODE0_OFF, 8'h01);
      wr(CMPC_CTRL1_OFF, 8'h86);
      wr(CMPC_MUX1_OFF, 8'h13);
      wr(CMPC_MODE1_OFF, 8'h03);
      settle(2);
      check(a0.pos_hyst, 2'h2);
      check(a0.neg_hyst, 2'h3);
      check(a1.pos_hyst, 2'h1);
      check(a1.neg_hyst, 2'h2);
      check(a0.pos_sel, 2'h1);
      check(a0.neg_sel, 2'h3);
      check(a1.pos_sel, 2'h3);
      check(a1.neg_sel, 2'h1);
      check(a0.response, 2'h1);
      check(a1.response, 2'h3);
      rd_check(CMPC_MUX1_OFF, 8'h13);
      rd_check(CMPC_CTRL0_OFF, 8'hCB);
   endtask : t_fields

   task automatic t_reset_source;
      wr(CMPC_RST_SRC_OFF, 8'h01);
      set_res(2'h2);
      check(rst_req, 1'b1);
      set_res(2'h3);
      check(rst_req, 1'b0);
      set_res(2'h1);
      rd_check(CMPC_IRQ_STAT_OFF, 8'h0B);
      check(irq, 1'b1);
      wr(CMPC_PIN_SEL_OFF, 8'h02);
      @(posedge clk);
      res <= 2'h3;
      @(posedge clk);
      #1;
      check(pin1, 1'b1);
      check(lat1, 1'b0);
   endtask : t_reset_source

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   // Watchdog well beyond the expected few hundred cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      mismatches++;
      summarize;
   end

   initial
   begin
      reset = 1'b1;
      bus = '0;
      res = 2'h0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      t_reset_values;
      t_enable;
      t_edges;
      t_pins;
      t_fields;
      t_reset_source;
      summarize;
   end
endmodule : cmpc_top_bench
